// ---- hw/conv_clock_gen.sv ----
// Purpose: conversion clock enable, one pclk-wide tick per conversion clock period
// Assumes: run stays high for the whole sample and conversion
// Notes: the rc oscillator is modelled as a further divide of pclk
`timescale 1ns/1ps
module conv_clock_gen
  import sar_adc_pkg::*;
#(
  parameter int unsigned DIV_A = 2,
  parameter int unsigned DIV_B = 8,
  parameter int unsigned DIV_C = 32,
  parameter int unsigned DIV_RC = 40
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic run,
  input wire conv_clk_t clk_sel,
  // enable out
  output logic tick
);

  div_state_t s;
  div_state_t next_s;
  logic [7:0] lim;

  always_comb begin
    case (clk_sel)
      CLK_DIV_A: lim = 8'(DIV_A - 1);
      CLK_DIV_B: lim = 8'(DIV_B - 1);
      CLK_DIV_C: lim = 8'(DIV_C - 1);
      default: lim = 8'(DIV_RC - 1);
    endcase
  end

  // restart from zero on every run so the first period is always whole
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = 8'h00;
    end else if (s.cnt >= lim) begin
      next_s.cnt = 8'h00;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

// ---- hw/sar_adc_control.sv ----
// Purpose: control of an 8-bit successive-approximation converter behind an APB slave
// Assumes: comp_above is the comparator, high when the held input is at or above dac_code
// Notes: zero-wait APB slave; unmapped addresses answer pslverr
`timescale 1ns/1ps
`include "sar_adc_regs.svh"
module sar_adc_control
  import sar_adc_pkg::*;
#(
  parameter int unsigned DIV_A = 2,
  parameter int unsigned DIV_B = 8,
  parameter int unsigned DIV_C = 32,
  parameter int unsigned DIV_RC = 40,
  parameter int unsigned SAMPLE_TICKS = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog front end
  input wire logic comp_above,
  output analog_out_t analog_out,
  // system
  input wire logic sleep_mode,
  output logic irq_request,
  output logic wake_request
);

  localparam logic [7:0] INSTR_WAIT = 8'(`ADC_INSTR_CYCLES - 1);
  localparam logic [7:0] SAMPLE_WAIT = 8'(SAMPLE_TICKS - 1);

  adc_state_t s;
  adc_state_t next_s;
  logic tick;
  logic [7:0] partial;
  logic [2:0] idx_down;
  logic sel_flag, sel_irqen, sel_result, sel_ctrl, mapped;
  logic wr, wr_ctrl, busy, running;
  logic start, cancel, sleep_abort, finish;
  logic [31:0] rd_mux;

  // address decode, byte address is index * 4
  assign sel_flag = paddr == {`ADC_FLAG_IDX, 2'b00};
  assign sel_irqen = paddr == {`ADC_IRQEN_IDX, 2'b00};
  assign sel_result = paddr == {`ADC_RESULT_IDX, 2'b00};
  assign sel_ctrl = paddr == {`ADC_CTRL_IDX, 2'b00};
  assign mapped = sel_flag | sel_irqen | sel_result | sel_ctrl;

  assign wr = psel & penable & pwrite;
  assign wr_ctrl = wr & sel_ctrl;
  assign busy = s.st != SEQ_IDLE;
  assign running = (s.st == SEQ_SAMPLE) | (s.st == SEQ_CONVERT);

  // a start needs the enable bit set in the same write as go
  assign start = wr_ctrl & pwdata[`ADC_CTRL_GO_BIT] & pwdata[`ADC_CTRL_EN_BIT] & !busy;
  assign cancel = wr_ctrl & !pwdata[`ADC_CTRL_GO_BIT] & busy;
  assign sleep_abort = sleep_mode & (s.clk_sel != CLK_RC);
  assign finish = (s.st == SEQ_CONVERT) & tick & (s.bit_idx == 3'd0) & !sleep_abort;
  assign idx_down = 3'(s.bit_idx - 3'd1);

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (1'b1)
      sel_flag: rd_mux[`ADC_FLAG_BIT] = s.done_flag;
      sel_irqen: rd_mux[`ADC_IRQEN_BIT] = s.irq_en;
      sel_result: rd_mux[7:0] = s.result;
      sel_ctrl: begin
        rd_mux[`ADC_CTRL_EN_BIT] = s.enable;
        rd_mux[`ADC_CTRL_GO_BIT] = s.go;
        rd_mux[`ADC_CTRL_CHAN_LSB +: 2] = s.chan;
        rd_mux[`ADC_CTRL_CLK_LSB +: 2] = s.clk_sel;
      end
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  conv_clock_gen #(
    .DIV_A(DIV_A),
    .DIV_B(DIV_B),
    .DIV_C(DIV_C),
    .DIV_RC(DIV_RC)
  ) u_clock (
    .pclk(pclk),
    .presetn(presetn),
    .run(running),
    .clk_sel(s.clk_sel),
    .tick(tick)
  );

  sar_partial_fill u_fill (
    .sar(s.sar),
    .decided(s.decided),
    .filled(partial)
  );

  always_comb begin
    next_s = s;
    // read data is captured in the setup cycle so that it comes from a flop
    if (psel && !penable) begin
      next_s.prdata = rd_mux;
    end
    if (wr && sel_result) begin
      next_s.result = pwdata[7:0];
    end
    if (wr_ctrl) begin
      next_s.enable = pwdata[`ADC_CTRL_EN_BIT];
      next_s.go = pwdata[`ADC_CTRL_GO_BIT] & pwdata[`ADC_CTRL_EN_BIT];
      next_s.chan = pwdata[`ADC_CTRL_CHAN_LSB +: 2];
      next_s.clk_sel = conv_clk_t'(pwdata[`ADC_CTRL_CLK_LSB +: 2]);
    end
    if (wr && sel_flag) begin
      next_s.done_flag = pwdata[`ADC_FLAG_BIT];
    end
    if (wr && sel_irqen) begin
      next_s.irq_en = pwdata[`ADC_IRQEN_BIT];
    end

    case (s.st)
      SEQ_IDLE: begin
        if (start && s.clk_sel == CLK_RC) begin
          next_s.st = SEQ_DELAY;
          next_s.wait_cnt = INSTR_WAIT;
        end else if (start) begin
          next_s.st = SEQ_SAMPLE;
          next_s.wait_cnt = SAMPLE_WAIT;
        end
      end
      SEQ_DELAY: begin
        if (s.wait_cnt == 8'h00) begin
          next_s.st = SEQ_SAMPLE;
          next_s.wait_cnt = SAMPLE_WAIT;
        end else begin
          next_s.wait_cnt = s.wait_cnt - 8'h01;
        end
      end
      SEQ_SAMPLE: begin
        if (tick && s.wait_cnt == 8'h00) begin
          next_s.st = SEQ_CONVERT;
          next_s.sar = `ADC_SAR_START;
          next_s.decided = 8'h00;
          next_s.bit_idx = 3'd7;
        end else if (tick) begin
          next_s.wait_cnt = s.wait_cnt - 8'h01;
        end
      end
      SEQ_CONVERT: begin
        if (tick) begin
          // keep or drop the trial bit, then try the next one down
          next_s.sar[s.bit_idx] = comp_above;
          next_s.decided[s.bit_idx] = 1'b1;
          if (s.bit_idx != 3'd0) begin
            next_s.sar[idx_down] = 1'b1;
            next_s.bit_idx = idx_down;
          end
        end
      end
      default: next_s.st = SEQ_IDLE;
    endcase

    // a clear of go that meets the final bit loses to completion
    if (cancel && !finish && !sleep_abort) begin
      next_s.st = SEQ_IDLE;
      if (s.st == SEQ_CONVERT && s.decided != 8'h00) begin
        next_s.result = partial;
      end
    end

    if (finish) begin
      next_s.st = SEQ_IDLE;
      next_s.go = 1'b0;
      next_s.done_flag = 1'b1;
      next_s.result = {s.sar[7:1], comp_above};
      if (sleep_mode && !s.irq_en) begin
        next_s.power_down = 1'b1;
      end
      if (sleep_mode && s.irq_en) begin
        next_s.wake = 1'b1;
      end
    end

    // the enable bit is left alone; the analog side is switched off and a busy sequencer drops to idle with go cleared
    if (sleep_abort) begin
      next_s.power_down = 1'b1;
      if (busy) begin
        next_s.st = SEQ_IDLE;
        next_s.go = 1'b0;
      end
    end
    if (!sleep_mode) begin
      next_s.power_down = 1'b0;
      next_s.wake = 1'b0;
    end

    if (!next_s.enable) begin
      next_s.st = SEQ_IDLE;
      next_s.go = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.result <= `ADC_RESULT_RST;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel & penable & !mapped;

  // a channel code of 3 connects no input
  assign analog_out.channel_onehot = {s.chan == 2'd2, s.chan == 2'd1, s.chan == 2'd0};
  assign analog_out.sample_hold = s.st == SEQ_SAMPLE;
  assign analog_out.dac_code = s.sar;
  assign analog_out.converter_power = s.enable & !s.power_down;
  assign irq_request = s.done_flag & s.irq_en;
  assign wake_request = s.wake;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic rc_start;
  assign rc_start = start & (s.clk_sel == CLK_RC) & !sleep_abort;

  sequence seq_finish;
    finish;
  endsequence

  sequence seq_rc_wait;
    rc_start ##1 (s.st == SEQ_DELAY)[*4];
  endsequence

  AST_DONE_EFFECTS: assert property (seq_finish |=> !s.go && s.done_flag)
    else $error("completion did not clear go and set the flag");
  AST_RESULT_LOAD: assert property (seq_finish |=> s.result == {$past(s.sar[7:1]), $past(comp_above)})
    else $error("result not loaded at completion");
  AST_FLAG_STICKY: assert property (s.done_flag && !(wr && sel_flag) |=> s.done_flag)
    else $error("done flag cleared without a software write");
  AST_FLAG_NO_IE: assert property ((seq_finish and !s.irq_en) |=> s.done_flag && !irq_request)
    else $error("flag not set with interrupt disabled");
  AST_IRQ_RAISE: assert property ((seq_finish and s.irq_en) |=> irq_request)
    else $error("no interrupt request after completion");
  AST_OFF_IDLE: assert property (!s.enable |-> s.st == SEQ_IDLE && !s.go)
    else $error("sequencer busy while disabled");
  AST_RC_DELAY: assert property (seq_rc_wait |=> s.st == SEQ_SAMPLE || !s.go)
    else $error("rc start delay not one instruction cycle");
  AST_RC_DELAY_ENTER: assert property (rc_start |=> s.st == SEQ_DELAY)
    else $error("rc start skipped the delay");
  AST_SLEEP_ABORT: assert property (sleep_abort && busy
    |=> s.st == SEQ_IDLE && s.power_down && s.enable == $past(s.enable))
    else $error("sleep did not abort a non-rc conversion");
  AST_RC_SLEEP_OFF: assert property ((seq_finish and sleep_mode && !s.irq_en)
    |=> s.power_down && s.enable)
    else $error("converter not powered down after rc sleep conversion");
  AST_WAKE: assert property ((seq_finish and sleep_mode && s.irq_en) |=> wake_request)
    else $error("no wake after sleep conversion");
  AST_PARTIAL: assert property (cancel && !finish && !sleep_abort && s.st == SEQ_CONVERT && s.decided != 8'h00
    |=> s.result == $past(partial))
    else $error("partial result not stored on early stop");
  AST_MSB_FIRST: assert property ($rose(s.st == SEQ_CONVERT) |-> s.sar == 8'h80 && s.bit_idx == 3'd7)
    else $error("conversion did not begin at the msb");

  // a software stop ends the run at once, unless it meets the final bit's tick, where completion wins
  sequence seq_cancel;
    cancel && !finish && !sleep_abort;
  endsequence

  AST_CANCEL_STOP: assert property (seq_cancel |=> s.st == SEQ_IDLE && !s.go)
    else $error("early clear of go did not stop the conversion");
  AST_BIT_STEP: assert property (s.st == SEQ_CONVERT && tick && s.bit_idx != 3'd0
    |=> s.bit_idx == $past(idx_down) && s.decided[$past(s.bit_idx)])
    else $error("conversion did not step down one bit per tick");
  AST_GO_NEEDS_EN: assert property (wr_ctrl && !pwdata[`ADC_CTRL_EN_BIT]
    |=> !s.enable && !s.go && s.st == SEQ_IDLE)
    else $error("converter kept running with the enable bit clear");

endmodule

// ---- hw/sar_adc_pkg.sv ----
// Purpose: types shared by the converter control modules
// Assumes: nothing beyond the register header
// Notes: widths follow the 8-bit result and three input channels
package sar_adc_pkg;

  typedef enum logic [1:0] {CLK_DIV_A, CLK_DIV_B, CLK_DIV_C, CLK_RC} conv_clk_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_DELAY, SEQ_SAMPLE, SEQ_CONVERT} seq_state_t;

  typedef struct packed {
    logic [2:0] channel_onehot;
    logic sample_hold;
    logic [7:0] dac_code;
    logic converter_power;
  } analog_out_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } div_state_t;

  typedef struct packed {
    seq_state_t st;
    logic enable;
    logic go;
    logic [1:0] chan;
    conv_clk_t clk_sel;
    logic [7:0] result;
    logic done_flag;
    logic irq_en;
    logic [7:0] sar;
    logic [7:0] decided;
    logic [2:0] bit_idx;
    logic [7:0] wait_cnt;
    logic power_down;
    logic wake;
    logic [31:0] prdata;
  } adc_state_t;

endpackage

// ---- hw/sar_adc_regs.svh ----
// Purpose: register map, field positions, reset values and timing counts of the converter control
// Assumes: 32-bit APB data, one aligned word per register, byte address = 4 x index
// Notes: definitions only
`ifndef SAR_ADC_REGS_SVH
`define SAR_ADC_REGS_SVH

// register indexes; byte address is index * 4
`define ADC_FLAG_IDX 6'h0c
`define ADC_IRQEN_IDX 6'h0d
`define ADC_RESULT_IDX 6'h1e
`define ADC_CTRL_IDX 6'h1f

// control register fields
`define ADC_CTRL_EN_BIT 0
`define ADC_CTRL_GO_BIT 1
`define ADC_CTRL_CHAN_LSB 2
`define ADC_CTRL_CLK_LSB 4
// flag and enable registers use bit 0
`define ADC_FLAG_BIT 0
`define ADC_IRQEN_BIT 0

// result reset value and sar start code
`define ADC_RESULT_RST 8'h00
`define ADC_SAR_START 8'h80

// timing: one instruction cycle, rounded up to whole pclk cycles
`define ADC_PCLK_NS 25
`define ADC_INSTR_NS 100
`define ADC_INSTR_CYCLES ((`ADC_INSTR_NS + `ADC_PCLK_NS - 1) / `ADC_PCLK_NS)

`endif

// ---- hw/sar_partial_fill.sv ----
// Purpose: result of an interrupted conversion
// Assumes: decided bits are contiguous from the msb downward
// Notes: undecided bits copy the lowest decided bit
`timescale 1ns/1ps
module sar_partial_fill (
  // inputs
  input wire logic [7:0] sar,
  input wire logic [7:0] decided,
  // output
  output logic [7:0] filled
);

  assign filled[7] = decided[7] ? sar[7] : 1'b0;

  genvar i;
  generate
    for (i = 0; i < 7; i++) begin : g_fill
      assign filled[i] = decided[i] ? sar[i] : filled[i + 1];
    end
  endgenerate

endmodule

// ---- verif/sar_adc_conversion_control_tb.sv ----
// Purpose: self-checking bench of the converter control over APB
// Assumes: default dividers, clock codes 0 to 2 pick DIV_A, DIV_B, DIV_C
// Notes: latencies are counted on negedges so flop updates have landed
`timescale 1ns/1ps
`include "sar_adc_regs.svh"
module sar_adc_conversion_control_tb;
  import sar_adc_pkg::*;
  localparam logic [7:0] A_FLAG = 8'(`ADC_FLAG_IDX * 4);
  localparam logic [7:0] A_IRQ = 8'(`ADC_IRQEN_IDX * 4);
  localparam logic [7:0] A_RES = 8'(`ADC_RESULT_IDX * 4);
  localparam logic [7:0] A_CTRL = 8'(`ADC_CTRL_IDX * 4);
  // sample plus eight bit ticks; the registered tick adds one pclk to each conversion
  localparam int CONV_TICKS = 2 + 8;
  localparam int LAT_RC = `ADC_INSTR_CYCLES + 40 * CONV_TICKS + 1;
  localparam logic [23:0] LVLS = 24'h01_c35a;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic comp_above, sleep_mode, irq_request, wake_request;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  analog_out_t analog_out;
  int n_fail = 0;
  int cmp_count = 0;

  sar_adc_control u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comp_above(comp_above), .analog_out(analog_out), .sleep_mode(sleep_mode),
    .irq_request(irq_request), .wake_request(wake_request)
  );
  sar_analog_model u_analog (.pclk(pclk), .levels(LVLS), .analog_out(analog_out), .comp_above(comp_above));

  task automatic print_verdict();
    if (n_fail == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic give_up();
    n_fail++;
    $display("[FAIL] %0t wait ran out", $time);
    print_verdict();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) give_up();
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    logic e;
    apb(1'b1, a, wd, x, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
    logic e;
    apb(1'b0, a, 32'h0000_0000, rdat, e);
  endtask

  function automatic logic [31:0] ctl(input logic g, input logic [1:0] ch, input logic [1:0] ck);
    ctl = {26'h000_0000, ck, ch, g, 1'b1};
  endfunction

  // accepted if some leading run of bits matches and the rest copy its lowest bit
  function automatic logic partial_ok(input logic [7:0] r, input logic [7:0] l);
    logic [7:0] m;
    partial_ok = 1'b0;
    for (int k = 1; k <= 8; k++) begin
      m = 8'hff << (8 - k);
      if (((r & m) === (l & m)) && ((r & ~m) === ({8{l[8 - k]}} & ~m))) partial_ok = 1'b1;
    end
  endfunction

  // go, then count cycles up to the interrupt request; -1 when not watching it
  task automatic start_and_wait(input logic [1:0] ch, input logic [1:0] ck, input int lat, input logic slp);
    int n;
    wr(A_CTRL, ctl(1'b0, ch, ck));
    repeat (4) @(posedge pclk);
    wr(A_CTRL, ctl(1'b1, ch, ck));
    sleep_mode <= slp;
    n = 0;
    if (lat >= 0) begin
      do begin
        @(negedge pclk);
        n++;
      end while (irq_request !== 1'b1 && n < 2000);
      chk(n, lat + 1, "latency");
    end else begin
      do begin
        rd(A_CTRL, d);
        n++;
      end while (d[1] !== 1'b0 && n < 500);
      if (n >= 500) give_up();
    end
  endtask

  task automatic t_reset();
    logic e;
    rd(A_CTRL, d);
    chk(d, 32'h0000_0000, "ctrl reset");
    rd(A_RES, d);
    chk(d, 32'h0000_0000, "result reset");
    apb(1'b0, 8'h04, 32'h0000_0000, d, e);
    chk(d, 32'h0000_0000, "unmapped data");
    chk(32'(e), 32'h0000_0001, "unmapped error");
    wr(A_RES, 32'h0000_00a5);
    rd(A_RES, d);
    chk(d, 32'h0000_00a5, "result rw");
  endtask

  task automatic t_conv(input logic [1:0] ch, input logic [1:0] ck, input logic ie);
    int lat;
    lat = (ck == 2'd0 ? 2 : (ck == 2'd1 ? 8 : 32)) * CONV_TICKS + 1;
    wr(A_IRQ, {31'h0, ie});
    start_and_wait(ch, ck, ie ? lat : -1, 1'b0);
    rd(A_CTRL, d);
    chk(d, ctl(1'b0, ch, ck), "go cleared");
    rd(A_RES, d);
    chk(d, {24'h00_0000, LVLS[ch * 8 +: 8]}, "result");
    repeat (20) @(posedge pclk);
    rd(A_FLAG, d);
    chk(d, 32'h0000_0001, "flag held");
    @(negedge pclk);
    chk(32'(irq_request), 32'(ie), "irq");
    wr(A_FLAG, 32'h0000_0000);
    @(negedge pclk);
    chk(32'(irq_request), 32'h0000_0000, "irq cleared");
  endtask

  task automatic t_abort();
    wr(A_CTRL, ctl(1'b1, 2'd1, 2'd0));
    repeat (12) @(posedge pclk);
    wr(A_CTRL, ctl(1'b0, 2'd1, 2'd0));
    rd(A_RES, d);
    chk(32'(partial_ok(d[7:0], LVLS[15:8])), 32'h0000_0001, "partial");
  endtask

  task automatic t_sleep();
    wr(A_CTRL, ctl(1'b1, 2'd0, 2'd0));
    repeat (6) @(posedge pclk);
    sleep_mode <= 1'b1;
    repeat (30) @(posedge pclk);
    @(negedge pclk);
    chk(32'(analog_out.converter_power), 32'h0000_0000, "sleep abort power");
    rd(A_CTRL, d);
    chk(d, ctl(1'b0, 2'd0, 2'd0), "sleep abort ctrl");
    rd(A_FLAG, d);
    chk(d, 32'h0000_0000, "sleep abort flag");
    sleep_mode <= 1'b0;
    wr(A_IRQ, 32'h0000_0001);
    start_and_wait(2'd2, 2'd3, LAT_RC, 1'b1);
    chk(32'(wake_request), 32'h0000_0001, "wake");
    @(posedge pclk);
    sleep_mode <= 1'b0;
    wr(A_FLAG, 32'h0000_0000);
    wr(A_IRQ, 32'h0000_0000);
    start_and_wait(2'd2, 2'd3, -1, 1'b1);
    @(negedge pclk);
    chk(32'({analog_out.converter_power, wake_request}), 32'h0000_0000, "rc sleep off");
    rd(A_CTRL, d);
    chk(d, ctl(1'b0, 2'd2, 2'd3), "rc sleep ctrl");
    rd(A_RES, d);
    chk(d, 32'h0000_0001, "rc result");
    sleep_mode <= 1'b0;
  endtask

  task automatic t_midreset();
    wr(A_CTRL, ctl(1'b1, 2'd0, 2'd0));
    repeat (8) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(A_CTRL, d);
    chk(d, 32'h0000_0000, "mid reset ctrl");
    chk(32'(analog_out.converter_power), 32'h0000_0000, "mid reset power");
    wr(A_CTRL, 32'h0000_0002);
    rd(A_CTRL, d);
    chk(d, 32'h0000_0000, "go without enable");
  endtask

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    sleep_mode = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int c = 0; c < 3; c++) t_conv(2'(c), 2'(c), 1'b1);
    t_conv(2'd1, 2'd0, 1'b0);
    t_abort();
    t_sleep();
    t_midreset();
    print_verdict();
  end

  initial begin
    repeat (90000) @(posedge pclk);
    give_up();
  end
endmodule

// ---- verif/sar_analog_model.sv ----
// Purpose: analog side of the converter, three inputs into one hold stage and an ideal comparator
// Assumes: input levels stay still while a conversion runs
// Notes: unpowered, or sampling with no input selected, the held value flips each cycle so a stale level never passes
`timescale 1ns/1ps
module sar_analog_model
  import sar_adc_pkg::*;
(
  // clock
  input wire logic pclk,
  // input levels, channel 0 in the low byte
  input wire logic [23:0] levels,
  // converter side
  input wire analog_out_t analog_out,
  output logic comp_above
);
  logic [7:0] held = 8'h00;

  always @(posedge pclk) begin
    if (!analog_out.converter_power) begin
      held <= ~held;
    end else if (analog_out.sample_hold) begin
      // one shared hold stage, only the selected input reaches it
      case (analog_out.channel_onehot)
        3'b001: held <= levels[7:0];
        3'b010: held <= levels[15:8];
        3'b100: held <= levels[23:16];
        default: held <= ~held;
      endcase
    end
  end

  // ideal comparator, so an exact search lands on the held level
  assign comp_above = (held >= analog_out.dac_code);
endmodule
